/* File: src/lmq_location_monitor.sv */
// Location monitor mailbox: decode, message queue, pending status, interrupt and isolation.
`timescale 1ns/100ps
module lmq_location_monitor #(
   parameter int unsigned TIMEOUT_CYCLES = lmq_pkg::BUS_TIMEOUT_CYCLES
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire lmq_pkg::lmq_image_s image_cfg,
   input  wire lmq_pkg::lmq_req_s   lcl_req,
   input  wire logic                vme_access_decode_n,
   output logic                     local_data_ack_n,
   output logic                     local_bus_error_n,
   output logic [31:0]              lcl_rdata,
   input  wire lmq_pkg::lmq_req_s   vme_req,
   output logic                     vme_ack,
   output logic                     vme_berr,
   input  wire logic                isolation_enter,
   input  wire logic                isolation_initiator_pin,
   output logic                     isolation_active,
   output logic                     outbound_queue_flush,
   output logic                     message_pending_flag,
   output logic                     message_interrupt_n
);
   localparam int unsigned CW = $clog2(lmq_pkg::QUEUE_DEPTH + 1);
   localparam logic [15:0] TO_LAST = 16'(TIMEOUT_CYCLES - 1);

   if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65536)
   begin : g_check
      $error("TIMEOUT_CYCLES must lie between 2 and 65536.");
   end

   // True when the address lies inside the image window.
   function automatic logic in_image(input logic [31:0] addr,
                                     input logic [31:0] base,
                                     input logic [31:0] mask);
      in_image = ((addr & ~mask) == (base & ~mask));
   endfunction : in_image

   // True when the address is the top longword of the image window.
   function automatic logic at_mailbox(input logic [31:0] addr,
                                       input logic [31:0] base,
                                       input logic [31:0] mask);
      at_mailbox = in_image(addr, base, mask) &&
                   ((addr[31:lmq_pkg::LW_LSB] & mask[31:lmq_pkg::LW_LSB]) ==
                    mask[31:lmq_pkg::LW_LSB]);
   endfunction : at_mailbox

   // Mailbox or image hit for either address space of a request.
   function automatic logic [1:0] classify(input lmq_pkg::lmq_req_s req,
                                           input lmq_pkg::lmq_image_s cfg);
      logic [31:0] a24;
      logic [31:0] b24;
      logic [31:0] m24;
      a24 = {8'h00, req.addr[23:0]};
      b24 = {8'h00, cfg.a24_base};
      m24 = {8'h00, cfg.a24_mask};
      if (req.space_a24)
      begin
         classify = {at_mailbox(a24, b24, m24), in_image(a24, b24, m24)};
      end
      else
      begin
         classify = {at_mailbox(req.addr, cfg.a32_base, cfg.a32_mask),
                     in_image(req.addr, cfg.a32_base, cfg.a32_mask)};
      end
   endfunction : classify

   // A 16-bit message fills the upper half with ones.
   function automatic logic [31:0] make_entry(input lmq_pkg::lmq_req_s req);
      make_entry = req.lower_only ? {lmq_pkg::UPPER_FILL, req.data[15:0]} : req.data;
   endfunction : make_entry

   // Initiator pin synchroniser: three stages, a change counts when the last two agree.
   logic init_s1_reg, init_s2_reg, init_s3_reg, init_reg, init_next;

   always_comb
   begin
      init_next = (init_s2_reg == init_s3_reg) ? init_s3_reg : init_reg;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         init_s1_reg <= 1'h0;
         init_s2_reg <= 1'h0;
         init_s3_reg <= 1'h0;
         init_reg    <= 1'h0;
      end
      else
      begin
         init_s1_reg <= isolation_initiator_pin;
         init_s2_reg <= init_s1_reg;
         init_s3_reg <= init_s2_reg;
         init_reg    <= init_next;
      end
   end

   // Message queue.
   logic                    q_in_valid, q_in_ready, q_out_valid, q_out_ready;
   logic [31:0]             q_in_data;
   logic [CW-1:0]           q_level;

   // Writes land only here; nothing passes the mailbox on to memory.
   lmq_msg_fifo #(
      .WIDTH (lmq_pkg::QUEUE_WIDTH),
      .DEPTH (lmq_pkg::QUEUE_DEPTH)
   ) u_queue (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (q_in_valid),
      .in_ready  (q_in_ready),
      .in_data   (q_in_data),
      .out_valid (q_out_valid),
      .out_ready (q_out_ready),
      .out_data  (lcl_rdata),
      .level     (q_level)
   );

   lmq_pkg::lmq_lstate_e lstate_reg, lstate_next;
   lmq_pkg::lmq_vstate_e vstate_reg, vstate_next;
   logic [15:0]          ltimer_reg, ltimer_next, vtimer_reg, vtimer_next;
   logic                 rr_reg, rr_next;
   logic                 lpush, vpush, grant_local, local_accept, vme_accept;
   logic [1:0]           lcls, vcls;
   logic                 lcl_is_qreg;

   // Arbitration between the two writers; round robin so neither starves.
   always_comb
   begin
      lpush        = (lstate_reg == lmq_pkg::L_PUSH);
      vpush        = (vstate_reg == lmq_pkg::V_PUSH);
      grant_local  = lpush && (!vpush || !rr_reg);
      local_accept = grant_local && q_in_ready;
      vme_accept   = vpush && !grant_local && q_in_ready;
      q_in_valid   = lpush || vpush;
      q_in_data    = grant_local ? make_entry(lcl_req) : make_entry(vme_req);
      rr_next      = rr_reg;
      if (local_accept)
      begin
         rr_next = 1'h1;
      end
      else if (vme_accept)
      begin
         rr_next = 1'h0;
      end
   end

   // Local side.
   always_comb
   begin
      lcls        = classify(lcl_req, image_cfg);
      lcl_is_qreg = (lcl_req.addr == lmq_pkg::QUEUE_REG_ADDR);
      lstate_next = lstate_reg;
      ltimer_next = 16'h0000;
      q_out_ready = 1'h0;
      case (lstate_reg)
         lmq_pkg::L_IDLE:
         begin
            if (lcl_req.valid)
            begin
               if (lcl_is_qreg && !lcl_req.write)
               begin
                  lstate_next = lmq_pkg::L_POP;
               end
               else if (lcl_is_qreg)
               begin
                  lstate_next = lmq_pkg::L_DONE;
               end
               else if (!vme_access_decode_n && lcls[1])
               begin
                  // Mailbox: writes queue after one extra cycle, reads fault.
                  lstate_next = lcl_req.write ? lmq_pkg::L_WAIT : lmq_pkg::L_ERR;
               end
               else if (!vme_access_decode_n && !lcls[0] && isolation_active)
               begin
                  lstate_next = lmq_pkg::L_IGNORE;
               end
               else
               begin
                  // Reflected and ordinary VME accesses belong to other logic.
                  lstate_next = lmq_pkg::L_ENDW;
               end
            end
         end
         lmq_pkg::L_WAIT:
         begin
            lstate_next = lmq_pkg::L_PUSH;
         end
         lmq_pkg::L_PUSH:
         begin
            ltimer_next = ltimer_reg + 16'h0001;
            if (local_accept)
            begin
               lstate_next = lmq_pkg::L_DONE;
            end
            else if (ltimer_reg == TO_LAST)
            begin
               lstate_next = lmq_pkg::L_ERR;
            end
         end
         lmq_pkg::L_POP:
         begin
            // An empty queue pops nothing yet is still answered.
            q_out_ready = 1'h1;
            lstate_next = lmq_pkg::L_DONE;
         end
         lmq_pkg::L_IGNORE:
         begin
            ltimer_next = ltimer_reg + 16'h0001;
            if (ltimer_reg == TO_LAST)
            begin
               lstate_next = lmq_pkg::L_ERR;
            end
         end
         lmq_pkg::L_DONE,
         lmq_pkg::L_ERR:
         begin
            lstate_next = lmq_pkg::L_ENDW;
         end
         lmq_pkg::L_ENDW:
         begin
            if (!lcl_req.valid)
            begin
               lstate_next = lmq_pkg::L_IDLE;
            end
         end
         default:
         begin
            lstate_next = lmq_pkg::L_IDLE;
         end
      endcase
   end

   // VMEbus side.
   always_comb
   begin
      vcls        = classify(vme_req, image_cfg);
      vstate_next = vstate_reg;
      vtimer_next = 16'h0000;
      case (vstate_reg)
         lmq_pkg::V_IDLE:
         begin
            if (vme_req.valid && vcls[1])
            begin
               vstate_next = vme_req.write ? lmq_pkg::V_PUSH : lmq_pkg::V_ERR;
            end
            else if (vme_req.valid)
            begin
               vstate_next = lmq_pkg::V_ENDW;
            end
         end
         lmq_pkg::V_PUSH:
         begin
            vtimer_next = vtimer_reg + 16'h0001;
            if (vme_accept)
            begin
               vstate_next = lmq_pkg::V_DONE;
            end
            else if (vtimer_reg == TO_LAST)
            begin
               vstate_next = lmq_pkg::V_ERR;
            end
         end
         lmq_pkg::V_DONE,
         lmq_pkg::V_ERR:
         begin
            vstate_next = lmq_pkg::V_ENDW;
         end
         lmq_pkg::V_ENDW:
         begin
            if (!vme_req.valid)
            begin
               vstate_next = lmq_pkg::V_IDLE;
            end
         end
         default:
         begin
            vstate_next = lmq_pkg::V_IDLE;
         end
      endcase
   end

   assign local_data_ack_n  = (lstate_reg != lmq_pkg::L_DONE);
   assign local_bus_error_n = (lstate_reg != lmq_pkg::L_ERR);
   assign vme_ack           = (vstate_reg == lmq_pkg::V_DONE);
   assign vme_berr          = (vstate_reg == lmq_pkg::V_ERR);

   // Status, interrupt and isolation.
   logic int_n_reg, int_n_next, pend_reg, pend_next;
   logic iso_reg, iso_next, flush_reg, flush_next;
   logic qread_done;

   always_comb
   begin
      qread_done = (lstate_reg == lmq_pkg::L_DONE) && lcl_is_qreg && !lcl_req.write;
      pend_next  = (q_level != '0);
      int_n_next = int_n_reg;
      // The level counts a push only after it is stored, so the interrupt follows it.
      if (q_level != '0)
      begin
         int_n_next = 1'h0;
      end
      else if (qread_done)
      begin
         int_n_next = 1'h1;
      end
      iso_next   = iso_reg;
      flush_next = 1'h0;
      if ((local_accept || vme_accept) && !init_reg)
      begin
         iso_next = 1'h0;
      end
      else if (isolation_enter && !iso_reg)
      begin
         // The inbound queue is left alone to drain; only outbound entries are dropped.
         iso_next   = 1'h1;
         flush_next = 1'h1;
      end
   end

   assign message_pending_flag = pend_reg;
   assign message_interrupt_n  = int_n_reg;
   assign isolation_active     = iso_reg;
   assign outbound_queue_flush = flush_reg;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         lstate_reg <= lmq_pkg::L_IDLE;
         vstate_reg <= lmq_pkg::V_IDLE;
         ltimer_reg <= 16'h0000;
         vtimer_reg <= 16'h0000;
         rr_reg     <= 1'h0;
         int_n_reg  <= lmq_pkg::INT_N_RST;
         pend_reg   <= lmq_pkg::PEND_RST;
         iso_reg    <= lmq_pkg::ISO_RST;
         flush_reg  <= 1'h0;
      end
      else
      begin
         lstate_reg <= lstate_next;
         vstate_reg <= vstate_next;
         ltimer_reg <= ltimer_next;
         vtimer_reg <= vtimer_next;
         rr_reg     <= rr_next;
         int_n_reg  <= int_n_next;
         pend_reg   <= pend_next;
         iso_reg    <= iso_next;
         flush_reg  <= flush_next;
      end
   end

endmodule : lmq_location_monitor

/* File: src/lmq_msg_fifo.sv */
// First-in first-out message store with registered read data.
`timescale 1ns/100ps
module lmq_msg_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   if (DEPTH < 2 || WIDTH < 1)
   begin : g_check
      $error("lmq_msg_fifo needs DEPTH of at least 2 and a nonzero WIDTH.");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [CW-1:0]    cnt_reg, cnt_next;
   logic [WIDTH-1:0] dout_reg, dout_next;
   logic             push, pop;

   assign in_ready  = (cnt_reg != CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = dout_reg;
   assign level     = cnt_reg;

   always_comb
   begin
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wptr_next = push ? ((wptr_reg == LAST) ? '0 : wptr_reg + PW'(1)) : wptr_reg;
      rptr_next = pop ? ((rptr_reg == LAST) ? '0 : rptr_reg + PW'(1)) : rptr_reg;
      // Read data comes out of a register, one cycle after the pop.
      dout_next = pop ? mem[rptr_reg] : dout_reg;
      cnt_next  = cnt_reg;
      if (push && !pop)
      begin
         cnt_next = cnt_reg + CW'(1);
      end
      else if (pop && !push)
      begin
         cnt_next = cnt_reg - CW'(1);
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg  <= '0;
         dout_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg  <= cnt_next;
         dout_reg <= dout_next;
      end
   end

   // The storage array has no reset; only written words are ever read back.
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wptr_reg] <= in_data;
      end
   end

endmodule : lmq_msg_fifo

/* File: src/lmq_pkg.sv */
// Shared constants, carrier structs and state encodings of the location monitor queue.
package lmq_pkg;

   // Clock rate and bus timer.
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned BUS_TIMEOUT_NS     = 64000;
   localparam int unsigned BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_NS / CLK_PERIOD_NS;

   // Message queue geometry.
   localparam int unsigned QUEUE_WIDTH = 32;
   localparam int unsigned QUEUE_DEPTH = 31;

   // Local address of the queue register, and the fill used for 16-bit messages.
   localparam logic [31:0] QUEUE_REG_ADDR = 32'hFFFF0080;
   localparam logic [15:0] UPPER_FILL     = 16'hFFFF;
   localparam int unsigned LW_LSB         = 2;

   // Reset values of the status outputs.
   localparam logic INT_N_RST = 1'h1;
   localparam logic ISO_RST   = 1'h0;
   localparam logic PEND_RST  = 1'h0;

   // One bus request, held stable by the requester until it sees an answer.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        space_a24;
      logic        lower_only;
      logic [31:0] addr;
      logic [31:0] data;
   } lmq_req_s;

   // Slave image windows; a mask bit set marks an offset bit inside the image.
   typedef struct packed {
      logic [31:0] a32_base;
      logic [31:0] a32_mask;
      logic [23:0] a24_base;
      logic [23:0] a24_mask;
   } lmq_image_s;

   typedef enum logic [2:0] {
      L_IDLE   = 3'h0,
      L_WAIT   = 3'h1,
      L_PUSH   = 3'h3,
      L_POP    = 3'h2,
      L_DONE   = 3'h6,
      L_ERR    = 3'h7,
      L_IGNORE = 3'h5,
      L_ENDW   = 3'h4
   } lmq_lstate_e;

   typedef enum logic [2:0] {
      V_IDLE = 3'h0,
      V_PUSH = 3'h1,
      V_DONE = 3'h3,
      V_ERR  = 3'h2,
      V_ENDW = 3'h6
   } lmq_vstate_e;

endpackage : lmq_pkg

/* File: tb/lmq_location_monitor_sva.sv */
// Concurrent checks on the ports of the location monitor queue.
`timescale 1ns/100ps
module lmq_location_monitor_sva #(
   parameter int unsigned TIMEOUT_CYCLES = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic local_data_ack_n,
   input wire logic local_bus_error_n,
   input wire logic vme_ack,
   input wire logic vme_berr,
   input wire logic isolation_enter,
   input wire logic isolation_active,
   input wire logic outbound_queue_flush,
   input wire logic message_pending_flag,
   input wire logic message_interrupt_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_PEND_WITH_INT: assert property (
      $fell(message_interrupt_n) |-> ##[0:1] message_pending_flag)
      else $error("pending flag missing while interrupt asserted");
   AST_INT_REL: assert property (
      $rose(message_interrupt_n) |-> !$past(local_data_ack_n))
      else $error("interrupt released without a queue read");
   AST_EMPTY_REL: assert property (
      $fell(message_pending_flag) |-> ##[0:1] message_interrupt_n)
      else $error("interrupt held after queue emptied");
   AST_INT_AFTER_WR: assert property (
      $fell(message_interrupt_n) |-> $past(vme_ack) || !$past(local_data_ack_n))
      else $error("interrupt asserted before a write completed");
   AST_ACK_ERR_EXCL: assert property (!local_bus_error_n |-> local_data_ack_n)
      else $error("local ack and bus error together");
   AST_VME_PULSE: assert property (vme_ack |=> !vme_ack && !vme_berr)
      else $error("remote ack longer than one cycle");
   AST_LCL_ERR_PULSE: assert property (!local_bus_error_n |=> local_bus_error_n)
      else $error("local bus error longer than one cycle");
   AST_FLUSH_ENTRY: assert property (
      outbound_queue_flush |-> isolation_active && !$past(isolation_active))
      else $error("outbound flush without isolation entry");
   AST_ISO_ENTER: assert property (
      $rose(isolation_active) |-> $past(isolation_enter))
      else $error("isolation entered without request");
   AST_ISO_EXIT: assert property (
      $fell(isolation_active) |-> ##[0:1] (vme_ack || !local_data_ack_n))
      else $error("isolation left without a mailbox write");
endmodule : lmq_location_monitor_sva

bind lmq_location_monitor lmq_location_monitor_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
   lmq_location_monitor_sva_inst (.core_clk(core_clk), .rst(rst),
   .local_data_ack_n(local_data_ack_n), .local_bus_error_n(local_bus_error_n),
   .vme_ack(vme_ack), .vme_berr(vme_berr), .isolation_enter(isolation_enter),
   .isolation_active(isolation_active), .outbound_queue_flush(outbound_queue_flush),
   .message_pending_flag(message_pending_flag), .message_interrupt_n(message_interrupt_n));

/* File: tb/lmq_vme_master.sv */
// Behavioural remote bus master issuing single slave cycles.
`timescale 1ns/100ps
module lmq_vme_master (
   input  wire logic         core_clk,
   output lmq_pkg::lmq_req_s vme_req,
   input  wire logic         vme_ack,
   input  wire logic         vme_berr
);
   initial vme_req = '0;
   // Response 1 is an acknowledge, 2 a bus error, 0 no answer at all.
   task automatic xfer(input logic wr, input logic a24, input logic lower,
                       input logic [31:0] addr, input logic [31:0] data,
                       output logic [1:0] resp, output int cyc);
      resp = 2'h0;
      cyc = 0;
      @(posedge core_clk);
      vme_req <= '{1'h1, wr, a24, lower, addr, data};
      while (resp == 2'h0 && cyc < 200)
      begin
         @(negedge core_clk);
         cyc++;
         if (vme_ack === 1'h1) resp = 2'h1;
         else if (vme_berr === 1'h1) resp = 2'h2;
      end
      @(posedge core_clk);
      // Released lines flip so a stale value can never be mistaken for a live one.
      vme_req <= '{1'h0, ~wr, ~a24, ~lower, ~addr, ~data};
   endtask : xfer
endmodule : lmq_vme_master

/* File: tb/testbench.sv */
// Self-checking bench for the location monitor queue.
`timescale 1ns/100ps
module testbench;
   localparam int unsigned TO = 16;
   localparam logic [31:0] MB32 = 32'h1000FFFC;
   localparam logic [31:0] MB24 = 32'h0020FFFC;
   logic                core_clk, rst, vme_access_decode_n, iso_enter, iso_pin;
   lmq_pkg::lmq_image_s image_cfg;
   lmq_pkg::lmq_req_s   lcl_req, vme_req;
   logic                local_data_ack_n, local_bus_error_n, vme_ack, vme_berr;
   logic                isolation_active, outbound_queue_flush;
   logic                message_pending_flag, message_interrupt_n;
   logic [31:0]         lcl_rdata, d, d2;
   logic [1:0]          r, r2;
   int                  c, c2, errors, num_checks, cycles;
   logic                ok;

   lmq_location_monitor #(.TIMEOUT_CYCLES(TO)) lmq_location_monitor_inst (
      .core_clk(core_clk), .rst(rst), .image_cfg(image_cfg), .lcl_req(lcl_req),
      .vme_access_decode_n(vme_access_decode_n), .local_data_ack_n(local_data_ack_n),
      .local_bus_error_n(local_bus_error_n), .lcl_rdata(lcl_rdata), .vme_req(vme_req),
      .vme_ack(vme_ack), .vme_berr(vme_berr), .isolation_enter(iso_enter),
      .isolation_initiator_pin(iso_pin), .isolation_active(isolation_active),
      .outbound_queue_flush(outbound_queue_flush),
      .message_pending_flag(message_pending_flag), .message_interrupt_n(message_interrupt_n));
   lmq_vme_master lmq_vme_master_inst (.core_clk(core_clk), .vme_req(vme_req),
      .vme_ack(vme_ack), .vme_berr(vme_berr));

   task automatic chk(input logic good, input string msg);
      num_checks++;
      if (good !== 1'h1)
      begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : settle

   task automatic lcl(input logic wr, input logic dec_n, input logic [31:0] addr,
                      input logic [31:0] data, output logic [31:0] rd,
                      output logic [1:0] resp, output int cyc);
      resp = 2'h0;
      cyc = 0;
      rd = 32'h0;
      @(posedge core_clk);
      lcl_req <= '{1'h1, wr, 1'h0, 1'h0, addr, data};
      vme_access_decode_n <= dec_n;
      while (resp == 2'h0 && cyc < 200)
      begin
         @(negedge core_clk);
         cyc++;
         rd = lcl_rdata;
         if (local_data_ack_n === 1'h0) resp = 2'h1;
         else if (local_bus_error_n === 1'h0) resp = 2'h2;
      end
      @(posedge core_clk);
      lcl_req <= '{1'h0, ~wr, 1'h1, 1'h1, ~addr, ~data};
      vme_access_decode_n <= 1'h1;
   endtask : lcl

   task automatic rdq(output logic [31:0] rd, output logic [1:0] resp, output int cyc);
      lcl(1'h0, 1'h1, lmq_pkg::QUEUE_REG_ADDR, 32'h0, rd, resp, cyc);
   endtask : rdq

   task automatic t_order();
      lcl(1'h1, 1'h0, MB32, 32'h12345678, d, r, c);
      chk(r === 2'h1 && c == 4, "local mailbox write timing");
      lmq_vme_master_inst.xfer(1'h1, 1'h1, 1'h1, MB24, 32'hAAAA5A5A, r, c);
      chk(r === 2'h1 && c == 3, "remote A24 mailbox write");
      settle(2);
      chk(message_pending_flag === 1'h1 && message_interrupt_n === 1'h0, "pending");
      rdq(d, r, c);
      chk(d === 32'h12345678 && c == 3, "oldest entry first");
      settle(2);
      chk(message_interrupt_n === 1'h0, "interrupt held with entries left");
      rdq(d, r, c);
      chk(d === 32'hFFFF5A5A, "lower word upper fill");
      settle(2);
      chk(message_interrupt_n === 1'h1 && message_pending_flag === 1'h0, "empty");
      $display("test order done");
   endtask : t_order

   task automatic t_errors();
      lcl(1'h0, 1'h0, MB32, 32'h0, d, r, c);
      chk(r === 2'h2 && c == 2, "local mailbox read error");
      lmq_vme_master_inst.xfer(1'h0, 1'h0, 1'h0, MB32, 32'h0, r, c);
      chk(r === 2'h2 && c == 2, "remote mailbox read error");
      rdq(d, r, c);
      chk(r === 2'h1, "empty queue read acknowledged");
      $display("test errors done");
   endtask : t_errors

   task automatic t_simul();
      fork
         lcl(1'h1, 1'h0, MB32, 32'h0000AAAA, d, r, c);
         begin
            @(posedge core_clk);
            lmq_vme_master_inst.xfer(1'h1, 1'h0, 1'h0, MB32, 32'h0000BBBB, r2, c2);
         end
      join
      chk(r === 2'h1 && r2 === 2'h1, "both writes answered");
      rdq(d, r, c);
      rdq(d2, r, c);
      chk((d === 32'hAAAA && d2 === 32'hBBBB) || (d === 32'hBBBB && d2 === 32'hAAAA),
          "both writes queued");
      $display("test simul done");
   endtask : t_simul

   task automatic t_full();
      ok = 1'h1;
      for (int i = 0; i < 31; i++)
      begin
         lmq_vme_master_inst.xfer(1'h1, 1'h0, 1'h0, MB32, 32'(i), r, c);
         ok &= (r === 2'h1);
      end
      chk(ok, "31 entries accepted");
      fork
         lmq_vme_master_inst.xfer(1'h1, 1'h0, 1'h0, MB32, 32'h1F, r2, c2);
         begin
            settle(6);
            rdq(d, r, c);
         end
      join
      chk(d === 32'h0 && r2 === 2'h1 && c2 > 6, "stalled write completes");
      lmq_vme_master_inst.xfer(1'h1, 1'h0, 1'h0, MB32, 32'h20, r, c);
      chk(r === 2'h2 && c == TO + 2, "stalled write times out");
      ok = 1'h1;
      for (int i = 1; i < 32; i++)
      begin
         ok &= (message_pending_flag === 1'h1);
         rdq(d, r, c);
         ok &= (d === 32'(i));
      end
      settle(2);
      chk(ok && message_interrupt_n === 1'h1, "drained in order");
      $display("test full done");
   endtask : t_full

   task automatic t_iso();
      @(posedge core_clk);
      iso_pin <= 1'h1;
      settle(5);
      @(posedge core_clk);
      iso_enter <= 1'h1;
      @(posedge core_clk);
      iso_enter <= 1'h0;
      @(negedge core_clk);
      chk(isolation_active === 1'h1 && outbound_queue_flush === 1'h1, "enter");
      lcl(1'h1, 1'h0, 32'h30000000, 32'h0, d, r, c);
      chk(r === 2'h2 && c == TO + 2, "ignored access times out");
      lcl(1'h1, 1'h0, MB32, 32'h5, d, r, c);
      chk(r === 2'h1 && isolation_active === 1'h1, "initiator keeps isolation");
      rdq(d, r, c);
      chk(r === 2'h1 && d === 32'h5, "own queue reachable");
      iso_pin <= 1'h0;
      settle(5);
      lmq_vme_master_inst.xfer(1'h1, 1'h0, 1'h0, MB32, 32'h6, r, c);
      settle(1);
      chk(isolation_active === 1'h0, "mailbox write leaves isolation");
      rdq(d, r, c);
      chk(r === 2'h1 && d === 32'h6, "releasing write was queued");
      $display("test iso done");
   endtask : t_iso

   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   initial
   begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         errors++;
         $display("mismatch at %0t: run did not finish", $time);
         summarize();
      end
   end

   initial
   begin
      rst = 1'h1;
      lcl_req = '0;
      vme_access_decode_n = 1'h1;
      iso_enter = 1'h0;
      iso_pin = 1'h0;
      image_cfg = '{32'h10000000, 32'h0000FFFF, 24'h200000, 24'h00FFFF};
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      t_order();
      t_errors();
      t_simul();
      t_full();
      t_iso();
      summarize();
   end
endmodule : testbench
